/* File: verilog/spma_pkg.sv */
// Constants for the serial program memory access engine
//Contract
// - Sample input on rising, shift output on falling
// - Echo 0x53 during third enable byte
// - Page loads by word address, low first
// - Page write commits buffer to selected page
// - EEPROM byte write auto-erases; 3.6 ms wait
// - EEPROM page write alters only loaded bytes
// - Read returns stored content in byte four
// - Decode enable and chip erase
// - Poll returns pending flag in bit zero
// - Decode extended address and page loads
// - Decode program memory and EEPROM reads
// - Decode lock, fuse, signature, calibration reads
// - Decode page write and EEPROM writes
// - Decode lock and fuse writes
// - Program memory uses any word address order
// - Releasing reset ends the session
// - Chip erase fills program memory, EEPROM and lock bits with 0xFF
// - Reject instructions until enable accepted
package spma_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int PAGE_WRITE_NS = 4_500_000;
  localparam int EEPROM_WRITE_NS = 3_600_000;
  localparam int ERASE_NS = 9_000_000;
  localparam int PAGE_WRITE_CYC = (PAGE_WRITE_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int EEPROM_WRITE_CYC = (EEPROM_WRITE_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int ERASE_CYC = (ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLASH_WORDS = 8192;
  localparam int PAGE_WORDS = 64;
  localparam int EE_BYTES = 256;
  localparam int EE_PAGE = 4;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [7:0] OPC_ENABLE_HI = 8'hAC;
  localparam logic [7:0] SUB_ENABLE = 8'h53;
  localparam logic [7:0] SUB_ERASE = 8'h80;
  localparam logic [7:0] SUB_LOCK_WR = 8'hE0;
  localparam logic [7:0] SUB_FUSE_LO_WR = 8'hA0;
  localparam logic [7:0] SUB_FUSE_HI_WR = 8'hA8;
  localparam logic [7:0] SUB_FUSE_EX_WR = 8'hA4;
  localparam logic [7:0] OPC_POLL = 8'hF0;
  localparam logic [7:0] OPC_LOAD_EXT = 8'h4D;
  localparam logic [7:0] OPC_LOAD_HI = 8'h48;
  localparam logic [7:0] OPC_LOAD_LO = 8'h40;
  localparam logic [7:0] OPC_LOAD_EE = 8'hC1;
  localparam logic [7:0] OPC_READ_HI = 8'h28;
  localparam logic [7:0] OPC_READ_LO = 8'h20;
  localparam logic [7:0] OPC_READ_EE = 8'hA0;
  localparam logic [7:0] OPC_READ_LOCK = 8'h58;
  localparam logic [7:0] OPC_READ_FUSE = 8'h50;
  localparam logic [7:0] SUB_FUSE_ALT = 8'h08;
  localparam logic [7:0] OPC_READ_SIG = 8'h30;
  localparam logic [7:0] OPC_READ_CAL = 8'h38;
  localparam logic [7:0] OPC_WRITE_PAGE = 8'h4C;
  localparam logic [7:0] OPC_WRITE_EE = 8'hC0;
  localparam logic [7:0] OPC_WRITE_EE_PAGE = 8'hC2;
  localparam logic [7:0] NV_RESET = 8'hFF;
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_PAGE = 2'b01,
    OP_ERASE = 2'b10
  } spma_op_type;
endpackage

/* File: verilog/spma_serial_prog.sv */
// Serial in-system programming engine with its memories
`timescale 1ns/1ps
`default_nettype none
module spma_serial_prog #(
  parameter int FLASH_AW = 13,
  parameter int PAGE_AW = 6,
  parameter int EE_AW = 8,
  parameter int EE_PAGE_AW = 2,
  parameter int PAGE_WRITE_CYC = spma_pkg::PAGE_WRITE_CYC,
  parameter int EEPROM_WRITE_CYC = spma_pkg::EEPROM_WRITE_CYC,
  parameter int ERASE_CYC = spma_pkg::ERASE_CYC,
  // Identity values are arbitrary
  parameter logic [23:0] SIGNATURE = 24'h0102_03,
  parameter logic [7:0] CALIBRATION = 8'h80
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic progResetN,
  input wire logic serialClk,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutOe,
  output logic sessionActive,
  output logic operationPendingFlag
);
  localparam int FLASH_N = 1 << FLASH_AW;
  localparam int PAGE_N = 1 << PAGE_AW;
  localparam int EE_N = 1 << EE_AW;
  localparam int EE_PAGE_N = 1 << EE_PAGE_AW;

  typedef struct packed {
    logic sck1;
    logic sck2;
    logic sck3;
    logic mosi1;
    logic mosi2;
    logic rstn1;
    logic rstn2;
    logic [4:0] bitCnt;
    logic [7:0] inShift;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] outByte;
    logic [7:0] outNext;
    logic loadPend;
    logic enabled;
    logic [7:0] ext;
    logic [7:0] lock;
    logic [7:0] fuseLo;
    logic [7:0] fuseHi;
    logic [7:0] fuseEx;
    logic [31:0] timer;
    spma_pkg::spma_op_type op;
    logic [FLASH_AW-1:0] sweep;
    logic [FLASH_AW-PAGE_AW-1:0] page;
    logic [EE_PAGE_N-1:0] eeLoaded;
  } spma_state_type;

  spma_state_type s;
  spma_state_type next_s;

  logic [15:0] flashMem [FLASH_N];
  logic [15:0] pageBuf [PAGE_N];
  logic [7:0] eeMem [EE_N];
  logic [7:0] eeBuf [EE_PAGE_N];

  logic rise;
  logic fall;
  logic busy;
  logic [7:0] ibyte;
  logic [23:0] rdWordCat;
  logic [FLASH_AW-1:0] rdWordAddr;
  logic [23:0] wrWordCat;
  logic [FLASH_AW-1:0] wrWordAddr;
  logic [9:0] rdEeCat;
  logic [9:0] wrEeCat;
  logic [15:0] rdWord;
  logic bufWe;
  logic bufHi;
  logic eeWe;
  logic eePageWe;
  logic eeBufWe;
  logic [7:0] sigByte;

  assign busy = (s.op != spma_pkg::OP_IDLE) || (s.timer != 32'h0000_0000);
  assign ibyte = {s.inShift[6:0], s.mosi2};
  assign rdWordCat = {s.ext, s.b2, ibyte};
  assign rdWordAddr = rdWordCat[FLASH_AW-1:0];
  assign wrWordCat = {s.ext, s.b2, s.b3};
  assign wrWordAddr = wrWordCat[FLASH_AW-1:0];
  assign rdEeCat = {s.b2[1:0], ibyte};
  assign wrEeCat = {s.b2[1:0], s.b3};
  assign rdWord = flashMem[rdWordAddr];

  always_comb begin
    case (ibyte[1:0])
      2'b00: sigByte = SIGNATURE[23:16];
      2'b01: sigByte = SIGNATURE[15:8];
      2'b10: sigByte = SIGNATURE[7:0];
      default: sigByte = spma_pkg::ERASED_BYTE;
    endcase
  end

  always_comb begin
    next_s = s;
    rise = 1'b0;
    fall = 1'b0;
    bufWe = 1'b0;
    bufHi = 1'b0;
    eeWe = 1'b0;
    eePageWe = 1'b0;
    eeBufWe = 1'b0;
    next_s.sck1 = serialClk;
    next_s.sck2 = s.sck1;
    next_s.sck3 = s.sck2;
    next_s.mosi1 = serialIn;
    next_s.mosi2 = s.mosi1;
    next_s.rstn1 = progResetN;
    next_s.rstn2 = s.rstn1;
    if (s.timer != 32'h0000_0000) begin
      next_s.timer = s.timer - 32'h0000_0001;
    end
    case (s.op)
      spma_pkg::OP_PAGE: begin
        next_s.sweep = s.sweep + 1'b1;
        if (s.sweep[PAGE_AW-1:0] == PAGE_AW'(PAGE_N - 1)) begin
          next_s.op = spma_pkg::OP_IDLE;
        end
      end
      spma_pkg::OP_ERASE: begin
        next_s.sweep = s.sweep + 1'b1;
        if (s.sweep == FLASH_AW'(FLASH_N - 1)) begin
          next_s.op = spma_pkg::OP_IDLE;
        end
      end
      default: begin
        next_s.op = spma_pkg::OP_IDLE;
      end
    endcase
    if (s.rstn2) begin
      // Reset pin high: normal operation, link ignored
      next_s.bitCnt = 5'h00;
      next_s.enabled = 1'b0;
      next_s.loadPend = 1'b0;
      next_s.outByte = 8'h00;
    end else begin
      rise = s.sck2 && !s.sck3;
      fall = !s.sck2 && s.sck3;
      if (fall) begin
        if (s.loadPend) begin
          next_s.outByte = s.outNext;
          next_s.loadPend = 1'b0;
        end else begin
          next_s.outByte = {s.outByte[6:0], 1'b0};
        end
      end
      if (rise) begin
        next_s.inShift = ibyte;
        next_s.bitCnt = s.bitCnt + 5'h01;
        if (s.bitCnt[2:0] == 3'h7) begin
          next_s.loadPend = 1'b1;
          next_s.outNext = ibyte;
          case (s.bitCnt[4:3])
            2'b00: begin
              next_s.b1 = ibyte;
            end
            2'b01: begin
              next_s.b2 = ibyte;
              // Echo of this byte goes out during the third byte
              if (s.b1 == spma_pkg::OPC_ENABLE_HI &&
                  ibyte == spma_pkg::SUB_ENABLE) begin
                next_s.enabled = 1'b1;
              end
            end
            2'b10: begin
              next_s.b3 = ibyte;
              if (s.enabled) begin
                case (s.b1)
                  spma_pkg::OPC_READ_HI: begin
                    next_s.outNext = rdWord[15:8];
                  end
                  spma_pkg::OPC_READ_LO: begin
                    next_s.outNext = rdWord[7:0];
                  end
                  spma_pkg::OPC_READ_EE: begin
                    next_s.outNext = eeMem[rdEeCat[EE_AW-1:0]];
                  end
                  spma_pkg::OPC_READ_LOCK: begin
                    next_s.outNext = (s.b2 == spma_pkg::SUB_FUSE_ALT) ?
                      s.fuseHi : s.lock;
                  end
                  spma_pkg::OPC_READ_FUSE: begin
                    next_s.outNext = (s.b2 == spma_pkg::SUB_FUSE_ALT) ?
                      s.fuseEx : s.fuseLo;
                  end
                  spma_pkg::OPC_READ_SIG: begin
                    next_s.outNext = sigByte;
                  end
                  spma_pkg::OPC_READ_CAL: begin
                    next_s.outNext = CALIBRATION;
                  end
                  spma_pkg::OPC_POLL: begin
                    next_s.outNext = {7'h00, busy};
                  end
                  default: begin
                    next_s.outNext = ibyte;
                  end
                endcase
              end
            end
            default: begin
              if (s.enabled) begin
                case (s.b1)
                  spma_pkg::OPC_LOAD_EXT: begin
                    next_s.ext = s.b3;
                  end
                  spma_pkg::OPC_LOAD_HI: begin
                    bufWe = 1'b1;
                    bufHi = 1'b1;
                  end
                  spma_pkg::OPC_LOAD_LO: begin
                    bufWe = 1'b1;
                  end
                  spma_pkg::OPC_LOAD_EE: begin
                    eeBufWe = 1'b1;
                    next_s.eeLoaded[s.b3[EE_PAGE_AW-1:0]] = 1'b1;
                  end
                  spma_pkg::OPC_WRITE_PAGE: begin
                    if (!busy) begin
                      next_s.op = spma_pkg::OP_PAGE;
                      next_s.page = wrWordAddr[FLASH_AW-1:PAGE_AW];
                      next_s.sweep = '0;
                      next_s.timer = 32'(PAGE_WRITE_CYC);
                    end
                  end
                  spma_pkg::OPC_WRITE_EE: begin
                    if (!busy) begin
                      eeWe = 1'b1;
                      next_s.timer = 32'(EEPROM_WRITE_CYC);
                    end
                  end
                  spma_pkg::OPC_WRITE_EE_PAGE: begin
                    if (!busy) begin
                      eePageWe = 1'b1;
                      next_s.eeLoaded = '0;
                      next_s.timer = 32'(EEPROM_WRITE_CYC);
                    end
                  end
                  spma_pkg::OPC_ENABLE_HI: begin
                    if (!busy) begin
                      case (s.b2)
                        spma_pkg::SUB_ERASE: begin
                          next_s.op = spma_pkg::OP_ERASE;
                          next_s.sweep = '0;
                          next_s.timer = 32'(ERASE_CYC);
                          next_s.lock = spma_pkg::NV_RESET;
                        end
                        spma_pkg::SUB_LOCK_WR: begin
                          // Lock bits only program; erase clears them
                          next_s.lock = s.lock & ibyte;
                        end
                        spma_pkg::SUB_FUSE_LO_WR: begin
                          next_s.fuseLo = ibyte;
                        end
                        spma_pkg::SUB_FUSE_HI_WR: begin
                          next_s.fuseHi = ibyte;
                        end
                        spma_pkg::SUB_FUSE_EX_WR: begin
                          next_s.fuseEx = ibyte;
                        end
                        default: begin
                          next_s.lock = s.lock;
                        end
                      endcase
                    end
                  end
                  default: begin
                    next_s.ext = s.ext;
                  end
                endcase
              end
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '{sck1: 1'b0, sck2: 1'b0, sck3: 1'b0, mosi1: 1'b0, mosi2: 1'b0,
        rstn1: 1'b1, rstn2: 1'b1, bitCnt: 5'h00, inShift: 8'h00,
        b1: 8'h00, b2: 8'h00, b3: 8'h00, outByte: 8'h00, outNext: 8'h00,
        loadPend: 1'b0, enabled: 1'b0, ext: 8'h00,
        lock: spma_pkg::NV_RESET, fuseLo: spma_pkg::NV_RESET,
        fuseHi: spma_pkg::NV_RESET, fuseEx: spma_pkg::NV_RESET,
        timer: 32'h0000_0000, op: spma_pkg::OP_IDLE, sweep: '0,
        page: '0, eeLoaded: '0};
    end else if (clkEn) begin
      s <= next_s;
    end
  end

  // Memory arrays and page buffers; an EEPROM page write stores every loaded byte in one cycle
  always_ff @(posedge ref_clk) begin
    if (clkEn) begin
      if (bufWe) begin
        if (bufHi) begin
          pageBuf[s.b3[PAGE_AW-1:0]][15:8] <= ibyte;
        end else begin
          pageBuf[s.b3[PAGE_AW-1:0]][7:0] <= ibyte;
        end
      end
      if (eeBufWe) begin
        eeBuf[s.b3[EE_PAGE_AW-1:0]] <= ibyte;
      end
      if (eeWe) begin
        // Whole byte replaced: erase and write in one step
        eeMem[wrEeCat[EE_AW-1:0]] <= ibyte;
      end
      if (eePageWe) begin
        for (int k = 0; k < EE_PAGE_N; k++) begin
          if (s.eeLoaded[k]) begin
            eeMem[{wrEeCat[EE_AW-1:EE_PAGE_AW], EE_PAGE_AW'(k)}] <=
              eeBuf[k];
          end
        end
      end
      if (s.op == spma_pkg::OP_PAGE) begin
        flashMem[{s.page, s.sweep[PAGE_AW-1:0]}] <=
          pageBuf[s.sweep[PAGE_AW-1:0]];
        pageBuf[s.sweep[PAGE_AW-1:0]] <= spma_pkg::ERASED_WORD;
      end
      if (s.op == spma_pkg::OP_ERASE) begin
        flashMem[s.sweep] <= spma_pkg::ERASED_WORD;
        if (s.sweep < FLASH_AW'(EE_N)) begin
          eeMem[s.sweep[EE_AW-1:0]] <= spma_pkg::ERASED_BYTE;
        end
      end
    end
  end

  assign serialOut = s.outByte[7];
  assign serialOutOe = !s.rstn2;
  assign sessionActive = !s.rstn2;
  assign operationPendingFlag = busy;
endmodule
`default_nettype wire

/* File: tb/spma_checker.sv */
// Port checker for the serial programming engine
`timescale 1ns/1ps
`default_nettype none
module spma_checker #(
  parameter int PAGE_WRITE_CYC = 200,
  parameter int EEPROM_WRITE_CYC = 200,
  parameter int ERASE_CYC = 200
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic progResetN,
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutOe,
  input wire logic sessionActive,
  input wire logic operationPendingFlag
);
  localparam int MIN_CYC = (PAGE_WRITE_CYC < EEPROM_WRITE_CYC) ?
    PAGE_WRITE_CYC : EEPROM_WRITE_CYC;
  localparam int MAX_CYC = 8192 + ERASE_CYC + PAGE_WRITE_CYC + 64;
  logic [31:0] pendCnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Enabled cycles in the current pending stretch
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) pendCnt <= 32'h0000_0000;
    else if (clkEn) pendCnt <= operationPendingFlag ?
      pendCnt + 32'h0000_0001 : 32'h0000_0000;
  end
  AST_OUT_ON_FALL: assert property (
    sessionActive && $past(sessionActive) && $changed(serialOut) |->
    !serialClk && !$past(serialClk, 2))
    else $error("serial output moved away from a falling clock");
  AST_SESSION_OPEN: assert property (
    !progResetN [*4] |-> sessionActive)
    else $error("session not open with reset pin low");
  AST_OE_DRIVE: assert property (!progResetN [*5] |-> serialOutOe)
    else $error("serial output not driven in session");
  AST_SESSION_CLOSE: assert property (progResetN [*5] |->
    !sessionActive && !serialOutOe)
    else $error("session still open with reset pin high");
  AST_PEND_IN_SESSION: assert property (
    $rose(operationPendingFlag) |-> sessionActive)
    else $error("pending raised outside session");
  AST_PEND_START: assert property ($rose(operationPendingFlag) |->
    serialClk && $past(serialClk, 2))
    else $error("pending raised away from a rising clock");
  AST_PEND_MIN: assert property ($fell(operationPendingFlag) |->
    pendCnt >= MIN_CYC) else $error("pending dropped too early");
  AST_PEND_MAX: assert property (operationPendingFlag |->
    pendCnt < MAX_CYC) else $error("pending held too long");
endmodule
bind spma_serial_prog spma_checker #(
  .PAGE_WRITE_CYC(PAGE_WRITE_CYC),
  .EEPROM_WRITE_CYC(EEPROM_WRITE_CYC),
  .ERASE_CYC(ERASE_CYC)
) chk (
  .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .progResetN(progResetN),
  .serialClk(serialClk), .serialIn(serialIn), .serialOut(serialOut),
  .serialOutOe(serialOutOe), .sessionActive(sessionActive),
  .operationPendingFlag(operationPendingFlag)
);
`default_nettype wire

/* File: tb/spma_prog_model.sv */
// Serial programmer model that clocks whole instruction frames
`timescale 1ns/1ps
`default_nettype none
module spma_prog_model (
  input wire logic ref_clk,
  input wire logic serialOut,
  output logic serialClk,
  output logic serialIn
);
  initial begin
    serialClk = 1'b0;
    serialIn = 1'b0;
  end
  // Four bytes MSB first, each clock phase eight reference cycles
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    for (int i = 31; i >= 0; i--) begin
      serialIn = tx[i];
      repeat (8) @(posedge ref_clk);
      #1 serialClk = 1'b1;
      rx[i] = serialOut;
      repeat (8) @(posedge ref_clk);
      #1 serialClk = 1'b0;
    end
    // Idle data line shows the inverse of the last bit
    serialIn = ~tx[0];
  endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Testbench for the serial programming engine
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk, rst, clkEn, progResetN, serialClk, serialIn;
  logic serialOut, serialOutOe, sessionActive, operationPendingFlag;
  logic [31:0] rx;
  int badCount = 0;
  int compares = 0;
  int cyc = 0;
  // Instruction, expected fourth byte, check flag, wait flag
  localparam logic [41:0] ROWS [25] = '{
    {32'hA000_0500, 8'hFF, 2'b10}, {32'h2000_4300, 8'hFF, 2'b10},
    {32'h4000_0334, 8'h00, 2'b00}, {32'h4800_0312, 8'h00, 2'b00},
    {32'h4C00_4300, 8'h00, 2'b01}, {32'h2000_4300, 8'h34, 2'b10},
    {32'h2800_4300, 8'h12, 2'b10}, {32'h2800_0300, 8'hFF, 2'b10},
    {32'hC000_055A, 8'h00, 2'b01}, {32'hA000_0500, 8'h5A, 2'b10},
    {32'hC100_0977, 8'h00, 2'b00}, {32'hC200_0800, 8'h00, 2'b01},
    {32'hA000_0900, 8'h77, 2'b10}, {32'hA000_0A00, 8'hFF, 2'b10},
    {32'hACE0_00FC, 8'h00, 2'b01},
    {32'h5800_0000, 8'hFC, 2'b10},
    {32'hACA0_00E2, 8'h00, 2'b01}, {32'h5000_0000, 8'hE2, 2'b10},
    {32'hACA8_00D9, 8'h00, 2'b01}, {32'h5808_0000, 8'hD9, 2'b10},
    {32'hACA4_00FE, 8'h00, 2'b01}, {32'h5008_0000, 8'hFE, 2'b10},
    {32'h3000_0000, 8'h5C, 2'b10}, {32'h3000_0300, 8'hFF, 2'b10},
    {32'h3800_0000, 8'h3B, 2'b10}};
  // Identity values are arbitrary
  spma_serial_prog #(.PAGE_WRITE_CYC(200), .EEPROM_WRITE_CYC(2000),
    .ERASE_CYC(200), .SIGNATURE(24'h5C_5C5C), .CALIBRATION(8'h3B)) dut (
    .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .progResetN(progResetN),
    .serialClk(serialClk), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutOe(serialOutOe), .sessionActive(sessionActive),
    .operationPendingFlag(operationPendingFlag));
  spma_prog_model prog (.ref_clk(ref_clk), .serialOut(serialOut),
    .serialClk(serialClk), .serialIn(serialIn));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic check(input string name, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      badCount++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Poll until the pending bit reads clear
  task automatic waitIdle;
    int n;
    n = 0;
    do begin
      prog.xfer(32'hF000_0000, rx);
      n++;
    end while (rx[0] !== 1'b0 && n < 40);
    check("pollRest", {1'b0, rx[7:1]}, 8'h00);
    check("pollDone", {7'h00, rx[0]}, 8'h00);
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      badCount++;
      summarize();
    end
  end
  initial begin
    rst = 1'b1;
    clkEn = 1'b1;
    progResetN = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    check("oeIdle", {7'h00, serialOutOe}, 8'h00);
    progResetN = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1 prog.xfer(32'hAC80_0000, rx);
    repeat (20) @(posedge ref_clk);
    #1 check("noErase", {7'h00, operationPendingFlag}, 8'h00);
    $display("test lockout done");
    prog.xfer(32'hAC53_0000, rx);
    check("echo", rx[15:8], 8'h53);
    prog.xfer(32'hAC80_0000, rx);
    check("eraseBusy", {7'h00, operationPendingFlag}, 8'h01);
    repeat (7800) @(posedge ref_clk);
    #1 prog.xfer(32'hF000_0000, rx);
    check("erasePoll", rx[7:0], 8'h01);
    waitIdle();
    $display("test erase done");
    foreach (ROWS[i]) begin
      prog.xfer(ROWS[i][41:10], rx);
      if (ROWS[i][1]) check("row", rx[7:0], ROWS[i][9:2]);
      if (ROWS[i][0]) waitIdle();
    end
    $display("test table done");
    prog.xfer(32'hC000_0611, rx);
    prog.xfer(32'hC000_0622, rx);
    waitIdle();
    prog.xfer(32'hA000_0600, rx);
    check("refused", rx[7:0], 8'h11);
    $display("test refusal done");
    // Clock enable low must hold the write timer where it stands
    prog.xfer(32'hC000_0733, rx);
    clkEn = 1'b0;
    repeat (3000) @(posedge ref_clk);
    #1 check("frozen", {7'h00, operationPendingFlag}, 8'h01);
    clkEn = 1'b1;
    waitIdle();
    prog.xfer(32'hA000_0700, rx);
    check("thawed", rx[7:0], 8'h33);
    $display("test freeze done");
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 check("reopen", {7'h00, sessionActive}, 8'h01);
    prog.xfer(32'h5800_0000, rx);
    check("lockedOut", rx[7:0], 8'h00);
    prog.xfer(32'hAC53_0000, rx);
    prog.xfer(32'h5800_0000, rx);
    check("lockReset", rx[7:0], 8'hFF);
    $display("test reset done");
    progResetN = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1 check("closed", {7'h00, sessionActive}, 8'h00);
    progResetN = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1 prog.xfer(32'h5800_0000, rx);
    check("reenable", rx[7:0], 8'h00);
    $display("test close done");
    summarize();
  end
endmodule
`default_nettype wire
